// >>> src/bbf_pkg.sv
package bbf_pkg;

    localparam int CLK_MHZ        = 250;
    localparam int ADDR_W         = 17;
    localparam int DATA_W         = 16;
    localparam int BYTE_W         = 8;
    localparam int CNT_W          = 8;
    localparam int TOP_DQ         = 15;

    // bus timing in ns, and the cycle counts derived from it
    localparam int READ_ACCESS_NS = 90;
    localparam int RESET_WAKE_NS  = 300;
    localparam int RESET_LOW_NS   = 100;
    localparam int WE_PULSE_NS    = 60;
    localparam int NS_PER_US      = 1000;

    localparam int READ_CYC  = (READ_ACCESS_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
    localparam int WAKE_CYC  = (RESET_WAKE_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
    localparam int RLOW_CYC  = (RESET_LOW_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
    localparam int WE_CYC    = (WE_PULSE_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;

    localparam logic [CNT_W-1:0] READ_CNT  = CNT_W'(READ_CYC);
    localparam logic [CNT_W-1:0] WAKE_CNT  = CNT_W'(WAKE_CYC);
    localparam logic [CNT_W-1:0] RLOW_CNT  = CNT_W'(RLOW_CYC);
    localparam logic [CNT_W-1:0] WE_CNT    = CNT_W'(WE_CYC);
    localparam logic [CNT_W-1:0] CNT_ZERO  = CNT_W'(0);
    localparam logic [CNT_W-1:0] CNT_ONE   = CNT_W'(1);

    localparam logic [DATA_W-1:0] DQ_NONE  = 16'h0000;
    localparam logic [DATA_W-1:0] DQ_ALL   = 16'hFFFF;
    localparam logic [DATA_W-1:0] DQ_BYTE  = 16'h80FF;
    localparam logic [DATA_W-1:0] DQ_HWSEL = 16'h8000;
    localparam logic [ADDR_W-1:0] ADDR_ZERO = 17'h00000;

    typedef enum logic [2:0] {
        BBF_OP_READ,
        BBF_OP_ID_READ,
        BBF_OP_COMMAND,
        BBF_OP_PROGRAM,
        BBF_OP_ERASE,
        BBF_OP_RESET
    } bbf_op_t;

    typedef struct packed {
        bbf_op_t             op;
        logic [ADDR_W-1:0]   addr;
        logic                hw_sel;
        logic [DATA_W-1:0]   data;
        logic                byte_mode;
        logic                boot_unlock;
    } bbf_req_t;

    typedef struct packed {
        logic [ADDR_W-1:0]   addr;
        logic                ce_n;
        logic                oe_n;
        logic                we_n;
        logic                byte_n;
        logic                reset_powerdown_n;
        logic                rp_unlock_hv;
        logic                id_mode_hv;
        logic                vpp_hv;
        logic [DATA_W-1:0]   dq_out;
        logic [DATA_W-1:0]   dq_oe;
    } bbf_pins_t;

endpackage

// >>> src/bbf_timer.sv
module bbf_timer (
    input  wire logic                       sys_clk,
    input  wire logic                       resetn,
    input  wire logic                       load,
    input  wire logic [bbf_pkg::CNT_W-1:0]  value,
    output logic                            expired
);

    logic [bbf_pkg::CNT_W-1:0] cnt;
    logic [bbf_pkg::CNT_W-1:0] next_cnt;

    always_comb begin
        next_cnt = cnt;
        if (load) begin
            next_cnt = value;
        end else if (cnt != bbf_pkg::CNT_ZERO) begin
            next_cnt = cnt - bbf_pkg::CNT_ONE;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            // the device wake-up wait starts as soon as reset is released
            cnt <= bbf_pkg::WAKE_CNT;
        end else begin
            cnt <= next_cnt;
        end
    end

    // true in the cycle the count reaches its last step
    assign expired = (cnt == bbf_pkg::CNT_ONE) || (cnt == bbf_pkg::CNT_ZERO);

endmodule // bbf_timer

// >>> src/bbf_host.sv
// How it works
// - host raises id-mode pin high-voltage qualifier to read signatures
// - host presents program data on the second write cycle of program
// - reset/power-down at unlock level permits boot block program and erase
// - host erases with setup then confirm at an address in the block
module bbf_host #(
    parameter logic [7:0] PROG_SETUP_CODE    = 8'h00,
    parameter logic [7:0] ERASE_SETUP_CODE   = 8'h00,
    parameter logic [7:0] ERASE_CONFIRM_CODE = 8'h00
) (
    input  wire logic                        sys_clk,
    input  wire logic                        resetn,
    input  wire logic                        req_valid,
    input  wire bbf_pkg::bbf_req_t           req,
    output logic                             req_ready,
    output logic                             rsp_valid,
    output logic [bbf_pkg::DATA_W-1:0]       rsp_data,
    input  wire logic [bbf_pkg::DATA_W-1:0]  dq_in,
    output bbf_pkg::bbf_pins_t               pins
);

    typedef enum {
        BBF_WAKE,
        BBF_IDLE,
        BBF_WR_SETUP,
        BBF_WR_PULSE,
        BBF_WR_HOLD,
        BBF_GAP,
        BBF_RD_WAIT,
        BBF_RST_LOW,
        BBF_DONE
    } bbf_state_t;

    bbf_state_t                    state;
    bbf_state_t                    next_state;
    bbf_pkg::bbf_req_t             cur;
    bbf_pkg::bbf_req_t             next_cur;
    bbf_pkg::bbf_pins_t            next_pins;
    logic                          second;
    logic                          next_second;
    logic                          next_req_ready;
    logic                          next_rsp_valid;
    logic [bbf_pkg::DATA_W-1:0]    next_rsp_data;
    logic                          tmr_load;
    logic [bbf_pkg::CNT_W-1:0]     tmr_value;
    logic                          tmr_expired;

    bbf_timer u_timer (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .load    (tmr_load),
        .value   (tmr_value),
        .expired (tmr_expired)
    );

    // data word driven during a write cycle of the current sequence
    function automatic logic [bbf_pkg::DATA_W-1:0] wr_word(input bbf_pkg::bbf_req_t r, input logic sec);
        logic [7:0] code;
        code = r.data[7:0];
        if (r.op == bbf_pkg::BBF_OP_PROGRAM && !sec) begin
            code = PROG_SETUP_CODE;
        end else if (r.op == bbf_pkg::BBF_OP_ERASE) begin
            code = sec ? ERASE_CONFIRM_CODE : ERASE_SETUP_CODE;
        end
        if (r.op == bbf_pkg::BBF_OP_PROGRAM && sec) begin
            wr_word = r.data;
        end else begin
            wr_word = {8'h00, code};
        end
    endfunction

    // place the half-word select on the top data line in byte mode
    function automatic logic [bbf_pkg::DATA_W-1:0] lane_word(input bbf_pkg::bbf_req_t r,
                                                              input logic [bbf_pkg::DATA_W-1:0] w);
        lane_word = w;
        if (r.byte_mode) begin
            lane_word = {r.hw_sel, 7'h00, w[7:0]};
        end
    endfunction

    always_comb begin
        next_state     = state;
        next_cur       = cur;
        next_pins      = pins;
        next_second    = second;
        next_req_ready = 1'b0;
        next_rsp_valid = 1'b0;
        next_rsp_data  = rsp_data;
        tmr_load       = 1'b0;
        tmr_value      = bbf_pkg::CNT_ZERO;
        case (state)
            BBF_WAKE: begin
                next_pins.reset_powerdown_n = 1'b1;
                if (tmr_expired) begin
                    next_state     = BBF_IDLE;
                    next_req_ready = 1'b1;
                end
            end
            BBF_IDLE: begin
                next_req_ready = 1'b1;
                if (req_valid && req_ready) begin
                    next_req_ready   = 1'b0;
                    next_cur         = req;
                    next_second      = 1'b0;
                    next_pins.byte_n = req.byte_mode ? 1'b0 : 1'b1;
                    next_pins.addr   = req.addr;
                    case (req.op)
                        bbf_pkg::BBF_OP_READ, bbf_pkg::BBF_OP_ID_READ: begin
                            next_pins.id_mode_hv = (req.op == bbf_pkg::BBF_OP_ID_READ);
                            next_pins.ce_n       = 1'b0;
                            next_pins.oe_n       = 1'b0;
                            next_pins.dq_oe      = req.byte_mode ? bbf_pkg::DQ_HWSEL : bbf_pkg::DQ_NONE;
                            next_pins.dq_out     = req.byte_mode ? bbf_pkg::DQ_HWSEL & {16{req.hw_sel}}
                                                                 : bbf_pkg::DQ_NONE;
                            tmr_load             = 1'b1;
                            tmr_value            = bbf_pkg::READ_CNT;
                            next_state           = BBF_RD_WAIT;
                        end
                        bbf_pkg::BBF_OP_RESET: begin
                            next_pins.reset_powerdown_n = 1'b0;
                            tmr_load                    = 1'b1;
                            tmr_value                   = bbf_pkg::RLOW_CNT;
                            next_state                  = BBF_RST_LOW;
                        end
                        default: begin
                            next_pins.vpp_hv       = (req.op == bbf_pkg::BBF_OP_PROGRAM) ||
                                                     (req.op == bbf_pkg::BBF_OP_ERASE);
                            next_pins.rp_unlock_hv = req.boot_unlock &&
                                                     (next_pins.vpp_hv == 1'b1);
                            next_state             = BBF_WR_SETUP;
                        end
                    endcase
                end
            end
            BBF_WR_SETUP: begin
                next_pins.ce_n   = 1'b0;
                next_pins.oe_n   = 1'b1;
                next_pins.dq_out = lane_word(cur, wr_word(cur, second));
                next_pins.dq_oe  = cur.byte_mode ? bbf_pkg::DQ_BYTE : bbf_pkg::DQ_ALL;
                next_pins.we_n   = 1'b0;
                tmr_load         = 1'b1;
                tmr_value        = bbf_pkg::WE_CNT;
                next_state       = BBF_WR_PULSE;
            end
            BBF_WR_PULSE: begin
                if (tmr_expired) begin
                    next_pins.we_n = 1'b1;
                    next_state     = BBF_WR_HOLD;
                end
            end
            BBF_WR_HOLD: begin
                // address and data stay one cycle past the strobe rise
                next_pins.ce_n  = 1'b1;
                next_pins.dq_oe = bbf_pkg::DQ_NONE;
                next_state      = BBF_GAP;
            end
            BBF_GAP: begin
                if (!second && (cur.op == bbf_pkg::BBF_OP_PROGRAM || cur.op == bbf_pkg::BBF_OP_ERASE)) begin
                    next_second = 1'b1;
                    next_state  = BBF_WR_SETUP;
                end else begin
                    next_state = BBF_DONE;
                end
            end
            BBF_RD_WAIT: begin
                if (tmr_expired) begin
                    next_rsp_data = cur.byte_mode ? {8'h00, dq_in[7:0]} : dq_in;
                    next_pins.ce_n = 1'b1;
                    next_pins.oe_n = 1'b1;
                    next_pins.dq_oe = bbf_pkg::DQ_NONE;
                    next_pins.id_mode_hv = 1'b0;
                    next_state     = BBF_DONE;
                end
            end
            BBF_RST_LOW: begin
                if (tmr_expired) begin
                    next_pins.reset_powerdown_n = 1'b1;
                    tmr_load                    = 1'b1;
                    tmr_value                   = bbf_pkg::WAKE_CNT;
                    next_state                  = BBF_WAKE;
                end
            end
            BBF_DONE: begin
                next_pins.vpp_hv       = 1'b0;
                next_pins.rp_unlock_hv = 1'b0;
                next_rsp_valid = 1'b1;
                next_req_ready = 1'b1;
                next_state     = BBF_IDLE;
            end
            default: begin
                next_state = BBF_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state                  <= BBF_WAKE;
            cur                    <= '0;
            second                 <= 1'b0;
            req_ready              <= 1'b0;
            rsp_valid              <= 1'b0;
            rsp_data               <= bbf_pkg::DQ_NONE;
            pins.addr              <= bbf_pkg::ADDR_ZERO;
            pins.ce_n              <= 1'b1;
            pins.oe_n              <= 1'b1;
            pins.we_n              <= 1'b1;
            pins.byte_n            <= 1'b1;
            pins.reset_powerdown_n <= 1'b0;
            pins.rp_unlock_hv      <= 1'b0;
            pins.id_mode_hv        <= 1'b0;
            pins.vpp_hv            <= 1'b0;
            pins.dq_out            <= bbf_pkg::DQ_NONE;
            pins.dq_oe             <= bbf_pkg::DQ_NONE;
        end else begin
            state     <= next_state;
            cur       <= next_cur;
            second    <= next_second;
            req_ready <= next_req_ready;
            rsp_valid <= next_rsp_valid;
            rsp_data  <= next_rsp_data;
            pins      <= next_pins;
        end
    end

endmodule // bbf_host

// >>> tb/bbf_host_asserts.sv
module bbf_host_chk (
    input wire logic                        sys_clk,
    input wire logic                        resetn,
    input wire logic                        req_valid,
    input wire bbf_pkg::bbf_req_t           req,
    input wire logic                        req_ready,
    input wire logic                        rsp_valid,
    input wire logic [bbf_pkg::DATA_W-1:0]  rsp_data,
    input wire logic [bbf_pkg::DATA_W-1:0]  dq_in,
    input wire bbf_pkg::bbf_pins_t          pins
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    sequence s_we_low; $fell(pins.we_n); endsequence
    sequence s_we_end; $rose(pins.we_n); endsequence
    property p_no_fight; !pins.oe_n |-> (pins.dq_oe & ~bbf_pkg::DQ_HWSEL) == bbf_pkg::DQ_NONE; endproperty
    a_no_fight: assert property (p_no_fight) else $error("host drives data during read");
    property p_we_sel; !pins.we_n |-> !pins.ce_n && pins.oe_n; endproperty
    a_we_sel: assert property (p_we_sel) else $error("write strobe without select");
    property p_we_width; s_we_low |-> !pins.we_n [*8]; endproperty
    a_we_width: assert property (p_we_width) else $error("write strobe too short");
    property p_we_latch; s_we_end |-> !pins.ce_n && $stable(pins.addr) && $stable(pins.dq_out); endproperty
    a_we_latch: assert property (p_we_latch) else $error("address or data moved at strobe end");
    property p_byte_float; !pins.byte_n |-> (pins.dq_oe & ~bbf_pkg::DQ_BYTE) == bbf_pkg::DQ_NONE; endproperty
    a_byte_float: assert property (p_byte_float) else $error("middle lines driven in byte mode");
    property p_id_read; pins.id_mode_hv |-> pins.we_n && !pins.vpp_hv && !pins.oe_n; endproperty
    a_id_read: assert property (p_id_read) else $error("signature level outside a read");
    property p_unlock; pins.rp_unlock_hv |-> pins.vpp_hv && pins.reset_powerdown_n; endproperty
    a_unlock: assert property (p_unlock) else $error("unlock level without write supply");
    property p_rp_low; !pins.reset_powerdown_n |-> pins.ce_n && pins.we_n && !pins.vpp_hv; endproperty
    a_rp_low: assert property (p_rp_low) else $error("bus active in power-down");
    property p_wake; $rose(pins.reset_powerdown_n) |-> !req_ready [*8]; endproperty
    a_wake: assert property (p_wake) else $error("request accepted during wake-up");
endmodule // bbf_host_chk

bind bbf_host bbf_host_chk i_bbf_host_chk (
    .sys_clk   (sys_clk),
    .resetn    (resetn),
    .req_valid (req_valid),
    .req       (req),
    .req_ready (req_ready),
    .rsp_valid (rsp_valid),
    .rsp_data  (rsp_data),
    .dq_in     (dq_in),
    .pins      (pins)
);

// >>> tb/bbf_flash_model.sv
module bbf_flash_model #(
    parameter logic [7:0]  PSET     = 8'h00,
    parameter logic [7:0]  ESET     = 8'h00,
    parameter logic [7:0]  ECONF    = 8'h00,
    parameter logic [15:0] MFR_CODE = 16'h0000,
    parameter logic [15:0] DEV_CODE = 16'h0000,
    parameter logic [3:0]  BOOT_BLK = 4'hF
) (
    input  wire bbf_pkg::bbf_pins_t pins,
    output logic [15:0]             dq_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [logic [16:0]];
    logic [1:0]  mode = 2'h0;
    logic [15:0] last = 16'h0000;
    int          wr_cnt = 0;

    function automatic logic [15:0] word_at(input logic [16:0] a);
        return mem.exists(a) ? mem[a] : 16'hFFFF;
    endfunction

    always @(posedge pins.we_n or negedge pins.reset_powerdown_n) begin
        logic [16:0] a;
        logic [15:0] d;
        logic [15:0] w;
        logic        ok;
        a = pins.addr;
        d = pins.dq_out;
        w = word_at(a);
        ok = pins.vpp_hv && (a[16:13] != BOOT_BLK || pins.rp_unlock_hv);
        if (pins.reset_powerdown_n !== 1'b1) begin
            mode = 2'h0;
        end else if (pins.ce_n === 1'b0) begin
            if (mode == 2'h1 && ok) begin
                if (pins.byte_n) w = w & d;
                else if (d[15]) w[15:8] = w[15:8] & d[7:0];
                else w[7:0] = w[7:0] & d[7:0];
                mem[a] = w;
            end else if (mode == 2'h2 && ok && d[7:0] == ECONF) begin
                foreach (mem[k]) begin
                    if (k[16:13] == a[16:13]) mem[k] = 16'hFFFF;
                end
            end
            mode = (mode != 2'h0) ? 2'h0 : (d[7:0] == PSET) ? 2'h1 : (d[7:0] == ESET) ? 2'h2 : 2'h0;
            wr_cnt++;
        end
    end

    // released lines show a changing pattern, never the last value
    always @(pins or wr_cnt) begin
        logic [15:0] w;
        w = pins.id_mode_hv ? (pins.addr[0] ? DEV_CODE : MFR_CODE) : word_at(pins.addr);
        if (!pins.byte_n) w = {~last[15:8], (pins.dq_out[15] && !pins.id_mode_hv) ? w[15:8] : w[7:0]};
        if (pins.reset_powerdown_n && !pins.ce_n && !pins.oe_n && pins.we_n) dq_in = w;
        else dq_in = ~last;
        last = dq_in;
    end
endmodule // bbf_flash_model

// >>> tb/tb.sv
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin err_count++; \
    $display("MISMATCH %s expected %h seen %h", nm, exp, got); end end

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0]       PSET  = 8'h5A;
    localparam logic [7:0]       ESET  = 8'hA5;
    localparam logic [7:0]       ECONF = 8'h3C;
    // arbitrary signature values
    localparam logic [15:0]      MFR   = 16'h1357;
    localparam logic [15:0]      DEV   = 16'h2468;
    localparam int               LIMIT = 20000;
    localparam bbf_pkg::bbf_op_t RD    = bbf_pkg::BBF_OP_READ;
    localparam bbf_pkg::bbf_op_t PG    = bbf_pkg::BBF_OP_PROGRAM;
    localparam bbf_pkg::bbf_op_t CMD   = bbf_pkg::BBF_OP_COMMAND;
    logic                        sys_clk = 1'b0;
    logic                        resetn = 1'b0;
    logic                        req_valid = 1'b0;
    bbf_pkg::bbf_req_t           req = '0;
    logic                        req_ready;
    logic                        rsp_valid;
    logic [15:0]                 rsp_data;
    logic [15:0]                 dq_in;
    bbf_pkg::bbf_pins_t          pins;
    int                          err_count = 0;
    int                          total_checks = 0;
    int                          cyc = 0;

    bbf_host #(.PROG_SETUP_CODE(PSET), .ERASE_SETUP_CODE(ESET), .ERASE_CONFIRM_CODE(ECONF)) i_bbf_host (
        .sys_clk   (sys_clk),
        .resetn    (resetn),
        .req_valid (req_valid),
        .req       (req),
        .req_ready (req_ready),
        .rsp_valid (rsp_valid),
        .rsp_data  (rsp_data),
        .dq_in     (dq_in),
        .pins      (pins)
    );
    bbf_flash_model #(.PSET(PSET), .ESET(ESET), .ECONF(ECONF), .MFR_CODE(MFR), .DEV_CODE(DEV)) i_bbf_flash_model (
        .pins  (pins),
        .dq_in (dq_in)
    );

    always #2 sys_clk = ~sys_clk;

    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == LIMIT) begin
            err_count++;
            complete_run();
        end
    end

    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // request held from a falling edge until a rising edge sees ready
    task automatic do_op(input bbf_pkg::bbf_op_t op, input logic [16:0] a, input logic [15:0] d, input logic hw,
                         input logic bm, input logic ul);
        int n;
        n = 0;
        @(negedge sys_clk);
        req_valid = 1'b1;
        req = '{op, a, hw, d, bm, ul};
        while (req_ready !== 1'b1 && n < 500) begin
            @(negedge sys_clk);
            n++;
        end
        @(negedge sys_clk);
        req_valid = 1'b0;
        while (req_ready !== 1'b1 && n < 1000) begin
            @(negedge sys_clk);
            n++;
        end
        if (req_ready !== 1'b1) begin
            err_count++;
            complete_run();
        end
        `CHK("op_done", op != bbf_pkg::BBF_OP_RESET, rsp_valid)
    endtask

    task automatic chk_rd(input string nm, input bbf_pkg::bbf_op_t op, input logic [16:0] a, input logic hw,
                          input logic bm, input logic [15:0] exp);
        do_op(op, a, 16'h0000, hw, bm, 1'b0);
        `CHK(nm, exp, rsp_data)
    endtask

    task automatic t_word;
        do_op(PG, 17'h00005, 16'hA5C3, 1'b0, 1'b0, 1'b0);
        do_op(PG, 17'h00006, 16'h0F0F, 1'b0, 1'b0, 1'b0);
        chk_rd("word_read", RD, 17'h00005, 1'b0, 1'b0, 16'hA5C3);
        $display("test word done");
    endtask

    task automatic t_byte;
        chk_rd("byte_hi", RD, 17'h00005, 1'b1, 1'b1, 16'h00A5);
        chk_rd("byte_lo", RD, 17'h00005, 1'b0, 1'b1, 16'h00C3);
        do_op(PG, 17'h00008, 16'h003C, 1'b1, 1'b1, 1'b0);
        chk_rd("byte_prog", RD, 17'h00008, 1'b0, 1'b0, 16'h3CFF);
        $display("test byte done");
    endtask

    task automatic t_id;
        logic [15:0] e;
        for (int i = 0; i < 4; i++) begin
            e = i[0] ? DEV : MFR;
            if (i[1]) e = {8'h00, e[7:0]};
            chk_rd("signature", bbf_pkg::BBF_OP_ID_READ, {16'h0000, i[0]}, 1'b1, i[1], e);
        end
        $display("test signature done");
    endtask

    task automatic t_boot;
        do_op(PG, 17'h1E010, 16'h0000, 1'b0, 1'b0, 1'b0);
        chk_rd("boot_locked", RD, 17'h1E010, 1'b0, 1'b0, 16'hFFFF);
        do_op(PG, 17'h1E010, 16'h0000, 1'b0, 1'b0, 1'b1);
        chk_rd("boot_open", RD, 17'h1E010, 1'b0, 1'b0, 16'h0000);
        $display("test boot done");
    endtask

    task automatic t_guard;
        do_op(CMD, 17'h00009, {8'h00, PSET}, 1'b0, 1'b0, 1'b0);
        do_op(CMD, 17'h00009, 16'h0000, 1'b0, 1'b0, 1'b0);
        chk_rd("no_supply", RD, 17'h00009, 1'b0, 1'b0, 16'hFFFF);
        do_op(CMD, 17'h00009, {8'h00, PSET}, 1'b0, 1'b0, 1'b0);
        do_op(bbf_pkg::BBF_OP_RESET, 17'h00000, 16'h0000, 1'b0, 1'b0, 1'b0);
        chk_rd("after_reset", RD, 17'h00006, 1'b0, 1'b0, 16'h0F0F);
        do_op(PG, 17'h00009, 16'h1234, 1'b0, 1'b0, 1'b0);
        chk_rd("read_mode", RD, 17'h00009, 1'b0, 1'b0, 16'h1234);
        $display("test guard done");
    endtask

    task automatic t_erase;
        do_op(bbf_pkg::BBF_OP_ERASE, 17'h00010, 16'h0000, 1'b0, 1'b0, 1'b0);
        chk_rd("erased", RD, 17'h00005, 1'b0, 1'b0, 16'hFFFF);
        chk_rd("other_block", RD, 17'h1E010, 1'b0, 1'b0, 16'h0000);
        $display("test erase done");
    endtask

    initial begin
        repeat (4) @(negedge sys_clk);
        resetn = 1'b1;
        t_word();
        t_byte();
        t_id();
        t_boot();
        t_guard();
        t_erase();
        complete_run();
    end
endmodule // tb
